// ===== rtl/fsrs_map.vh
// fsrs_map.vh: register offsets, field positions, reset values, timing counts
// assumes: included by the self-rewrite sequencer files, 250 MHz system clock
`ifndef FSRS_MAP_VH
`define FSRS_MAP_VH

// register byte offsets on the axi4-lite slave
`define FSRS_OFF_UNLOCK     8'h00
`define FSRS_OFF_SEGMENT    8'h04
`define FSRS_OFF_ADDR_LOW   8'h08
`define FSRS_OFF_ADDR_HIGH  8'h0C
`define FSRS_OFF_DATA_LOW   8'h10
`define FSRS_OFF_DATA_HIGH  8'h14
`define FSRS_OFF_CONTROL    8'h18
`define FSRS_OFF_STATUS     8'h1C
`define FSRS_OFF_SELF       8'h20
`define FSRS_OFF_PROTECT    8'h24

// unlock key values
`define FSRS_KEY_FIRST      8'hFA
`define FSRS_KEY_SECOND     8'hF5

// field positions
`define FSRS_BIT_ERASE_START 0
`define FSRS_BIT_BLOCK_MODE  1
`define FSRS_BIT_ERASE_BUSY  0
`define FSRS_BIT_WRITE_BUSY  1
`define FSRS_BIT_SELF_EN     0

// reset values
`define FSRS_RST_BYTE       8'h00
`define FSRS_RST_PROTECT    4'h0

// segment code of the data flash segment
`define FSRS_SEG_DATA       3'h4

// timing: printed maxima and derived cycle counts
`define FSRS_CLK_MHZ        250
`define FSRS_ERASE_TIME_MS  50
`define FSRS_WRITE_TIME_US  60
`define FSRS_ERASE_CYCLES   (`FSRS_ERASE_TIME_MS * 1000 * `FSRS_CLK_MHZ)
`define FSRS_WRITE_CYCLES   (`FSRS_WRITE_TIME_US * `FSRS_CLK_MHZ)

`endif

// ===== rtl/fsrs_busy_timer.v
// fsrs_busy_timer.v: down counter that times one erase or word write
// assumes: start is a one-cycle pulse, load value is at least one
`timescale 1ns/1ns
module fsrs_busy_timer
(
    input  wire        sys_clk_i,
    input  wire        arst_n_i,
    input  wire        start_i,
    input  wire [31:0] load_i,
    output wire        running_o,
    output reg         done_o
);
    reg [31:0] count;

    assign running_o = (count != 32'h0000_0000);

    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            count  <= 32'h0000_0000;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i)
                count <= load_i;
            else if (count != 32'h0000_0000)
            begin
                count <= count - 32'h0000_0001;
                if (count == 32'h0000_0001)
                    done_o <= 1'b1;
            end
        end
    end
endmodule

// ===== rtl/fsrs_protect_check.v
// fsrs_protect_check.v: decides whether a request hits a protected range
// assumes: purely combinational, fed from the sequencer's own registers and the block mode bit of the live control write
`timescale 1ns/1ns
`include "fsrs_map.vh"
module fsrs_protect_check
(
    input  wire [2:0]  segment_i,
    input  wire [15:0] addr_i,
    input  wire        is_block_i,
    input  wire [3:0]  protect_i,
    output wire        blocked_o
);
    wire in_window = (segment_i == `FSRS_SEG_DATA) && (addr_i[15:11] == 5'h00);
    wire [3:0] range_hit;

    genvar n;
    generate
        for (n = 0; n < 4; n = n + 1)
        begin : g_range
            // range n spans n*0200h .. n*0200h+01ffh
            assign range_hit[n] = protect_i[n] && (addr_i[10:9] == n);
        end
    endgenerate

    // block erase of 0000h-07ffh is refused by any protect bit
    assign blocked_o = in_window &&
                       (is_block_i ? (protect_i != 4'h0) : (range_hit != 4'h0));
endmodule

// ===== rtl/fsrs_sequencer.v
// fsrs_sequencer.v: flash self-rewrite sequencer with an axi4-lite register slave
// assumes: cpu software drives the registers, flash array macro sits on the flash_* outputs
//
// Summary of operation
// - Sector erase clears one aligned 512-byte region from segment and high address.
// - Block erase clears one aligned 2K-byte region from segment and high address.
// - Word write programs one 16-bit word at segment, high and low address.
// - Keys 0FAH then 0F5H unlock exactly one operation.
// - Operations start only while the self-rewrite enable bit is 1.
// - Writing 1 to erase start bit launches a sector or block erase.
// - Writing the high data byte launches the word write.
// - Operations run in background; the bus never stalls.
// - Erase busy flag is 1 throughout an erase, 0 after.
// - Write busy flag is 1 throughout a word write, 0 after.
// - Completion of any erase or write raises the done interrupt request.
// - Protect bit n blocks sector erase of its 512-byte range in segment 4.
// - Protect bit n blocks word writes into its range in segment 4.
// - Any protect bit blocks block erase of 0000H-07FFH in segment 4.
// - Any value other than 0F5H or 0FAH after 0FAH cancels the pending unlock.
// - Protect bits are set by writing 1 and stay set until reset.
// - Start requests are ignored while either busy flag is 1.
`timescale 1ns/1ns
`include "fsrs_map.vh"
module fsrs_sequencer
#(
    parameter [31:0] ERASE_CYCLES = `FSRS_ERASE_CYCLES,
    parameter [31:0] WRITE_CYCLES = `FSRS_WRITE_CYCLES
)
(
    input  wire        sys_clk_i,
    input  wire        arst_n_i,
    input  wire [7:0]  s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output wire        s_axi_awready_o,
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output wire        s_axi_wready_o,
    output reg  [1:0]  s_axi_bresp_o,
    output reg         s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    input  wire [7:0]  s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output wire        s_axi_arready_o,
    output reg  [31:0] s_axi_rdata_o,
    output reg  [1:0]  s_axi_rresp_o,
    output reg         s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    output reg         flash_erase_o,
    output reg         flash_block_o,
    output reg         flash_program_o,
    output reg  [2:0]  flash_segment_o,
    output reg  [15:0] flash_addr_o,
    output reg  [15:0] flash_data_o,
    output reg         rewrite_done_irq_o
);
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_ERASE = 3'b010;
    localparam [2:0] ST_WRITE = 3'b100;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg         unlock_armed;
    reg         unlock_open;
    reg  [2:0]  target_segment_reg;
    reg  [7:0]  target_addr_high_reg;
    reg  [7:0]  target_addr_low_reg;
    reg  [7:0]  program_data_low_reg;
    reg  [7:0]  program_data_high_reg;
    reg         block_mode;
    reg         self_rewrite_enable_bit;
    reg  [3:0]  range_protect_reg;

    // write channel: both halves held until both present, taken together
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;

    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;

    wire aw_fire  = s_axi_awvalid_i && s_axi_awready_o;
    wire w_fire   = s_axi_wvalid_i && s_axi_wready_o;
    wire have_aw  = aw_held || aw_fire;
    wire have_w   = w_held || w_fire;
    wire wr_go    = have_aw && have_w && !s_axi_bvalid_o;
    wire [7:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr_i;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata_i;
    wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb_i;
    wire        wr_lane0 = wr_go && wr_strb[0];
    wire [7:0]  wr_byte  = wr_data[7:0];

    function is_mapped;
        input [7:0] addr;
        begin
            is_mapped = (addr[1:0] == 2'b00) && (addr <= `FSRS_OFF_PROTECT);
        end
    endfunction

    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = wr_lane0 && (addr == off);
        end
    endfunction

    wire wr_unlock  = hit(wr_addr, `FSRS_OFF_UNLOCK);
    wire wr_control = hit(wr_addr, `FSRS_OFF_CONTROL);
    wire wr_data_hi = hit(wr_addr, `FSRS_OFF_DATA_HIGH);

    wire busy_erase = (state == ST_ERASE);
    wire busy_write = (state == ST_WRITE);
    wire any_busy   = busy_erase || busy_write;

    // start requests
    wire req_erase = wr_control && wr_byte[`FSRS_BIT_ERASE_START];
    wire req_write = wr_data_hi;
    wire req_any   = req_erase || req_write;
    wire req_block = wr_byte[`FSRS_BIT_BLOCK_MODE];

    wire blocked;
    fsrs_protect_check u_protect
    (
        .segment_i  (target_segment_reg),
        .addr_i     ({target_addr_high_reg, req_erase ? 8'h00 : target_addr_low_reg}),
        .is_block_i (req_erase && req_block),
        .protect_i  (range_protect_reg),
        .blocked_o  (blocked)
    );

    wire seg_ok = (target_segment_reg == `FSRS_SEG_DATA);
    wire accept = req_any && unlock_open && self_rewrite_enable_bit &&
                  !any_busy && !blocked && seg_ok;

    wire timer_done;
    // one less: the done pulse lands a cycle late, so busy spans exactly the count
    fsrs_busy_timer u_timer
    (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .start_i   (accept),
        .load_i    ((req_erase ? ERASE_CYCLES : WRITE_CYCLES) - 32'h0000_0001),
        .running_o (),
        .done_o    (timer_done)
    );

    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (accept)
                    next_state = req_erase ? ST_ERASE : ST_WRITE;
            ST_ERASE:
                if (timer_done)
                    next_state = ST_IDLE;
            ST_WRITE:
                if (timer_done)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state              <= ST_IDLE;
            rewrite_done_irq_o <= 1'b0;
        end
        else
        begin
            state              <= next_state;
            rewrite_done_irq_o <= timer_done && any_busy;
        end
    end

    // unlock key tracking
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            unlock_armed <= 1'b0;
            unlock_open  <= 1'b0;
        end
        else if (req_any)
        begin
            unlock_armed <= 1'b0;
            unlock_open  <= 1'b0;
        end
        else if (wr_unlock)
        begin
            if (unlock_armed && wr_byte == `FSRS_KEY_SECOND)
            begin
                unlock_armed <= 1'b0;
                unlock_open  <= 1'b1;
            end
            else
            begin
                unlock_armed <= (wr_byte == `FSRS_KEY_FIRST);
                unlock_open  <= 1'b0;
            end
        end
    end

    // software-visible control registers
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            target_segment_reg      <= 3'h0;
            target_addr_high_reg    <= `FSRS_RST_BYTE;
            target_addr_low_reg     <= `FSRS_RST_BYTE;
            program_data_low_reg    <= `FSRS_RST_BYTE;
            program_data_high_reg   <= `FSRS_RST_BYTE;
            block_mode              <= 1'b0;
            self_rewrite_enable_bit <= 1'b0;
            range_protect_reg       <= `FSRS_RST_PROTECT;
        end
        else
        begin
            if (hit(wr_addr, `FSRS_OFF_SEGMENT))
                target_segment_reg <= wr_byte[2:0];
            if (hit(wr_addr, `FSRS_OFF_ADDR_HIGH))
                target_addr_high_reg <= wr_byte;
            if (hit(wr_addr, `FSRS_OFF_ADDR_LOW))
                target_addr_low_reg <= wr_byte;
            if (hit(wr_addr, `FSRS_OFF_DATA_LOW))
                program_data_low_reg <= wr_byte;
            if (wr_data_hi)
                program_data_high_reg <= wr_byte;
            if (wr_control)
                block_mode <= req_block;
            if (hit(wr_addr, `FSRS_OFF_SELF))
                self_rewrite_enable_bit <= wr_byte[`FSRS_BIT_SELF_EN];
            if (hit(wr_addr, `FSRS_OFF_PROTECT))
                range_protect_reg <= range_protect_reg | wr_byte[3:0];
        end
    end

    // flash macro command, held for the whole operation
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            flash_erase_o   <= 1'b0;
            flash_block_o   <= 1'b0;
            flash_program_o <= 1'b0;
            flash_segment_o <= 3'h0;
            flash_addr_o    <= 16'h0000;
            flash_data_o    <= 16'h0000;
        end
        else if (accept)
        begin
            flash_erase_o   <= req_erase;
            flash_block_o   <= req_erase && req_block;
            flash_program_o <= req_write;
            flash_segment_o <= target_segment_reg;
            if (req_erase && req_block)
                flash_addr_o <= {target_addr_high_reg[7:3], 11'h000};
            else if (req_erase)
                flash_addr_o <= {target_addr_high_reg[7:1], 9'h000};
            else
                flash_addr_o <= {target_addr_high_reg, target_addr_low_reg[7:1], 1'b0};
            flash_data_o    <= {wr_byte, program_data_low_reg};
        end
        else if (timer_done)
        begin
            flash_erase_o   <= 1'b0;
            flash_block_o   <= 1'b0;
            flash_program_o <= 1'b0;
        end
    end

    // bus slave: one-cycle answers, no wait on the flash operation
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            aw_addr        <= 8'h00;
            w_data         <= 32'h0000_0000;
            w_strb         <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= 2'b00;
        end
        else
        begin
            if (aw_fire && !wr_go)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (w_fire && !wr_go)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (wr_go)
            begin
                aw_held        <= 1'b0;
                w_held         <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= is_mapped(wr_addr) ? 2'b00 : 2'b10;
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
        end
    end

    reg [31:0] rd_word;
    always @*
    begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr_i)
            `FSRS_OFF_SEGMENT:   rd_word = {29'h0, target_segment_reg};
            `FSRS_OFF_ADDR_LOW:  rd_word = {24'h0, target_addr_low_reg};
            `FSRS_OFF_ADDR_HIGH: rd_word = {24'h0, target_addr_high_reg};
            `FSRS_OFF_DATA_LOW:  rd_word = {24'h0, program_data_low_reg};
            `FSRS_OFF_DATA_HIGH: rd_word = {24'h0, program_data_high_reg};
            `FSRS_OFF_CONTROL:   rd_word = {30'h0, block_mode, busy_erase};
            `FSRS_OFF_STATUS:    rd_word = {30'h0, busy_write, busy_erase};
            `FSRS_OFF_SELF:      rd_word = {31'h0, self_rewrite_enable_bit};
            `FSRS_OFF_PROTECT:   rd_word = {28'h0, range_protect_reg};
            default:             rd_word = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= 2'b00;
        end
        else if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_word;
            s_axi_rresp_o  <= is_mapped(s_axi_araddr_i) ? 2'b00 : 2'b10;
        end
        else if (s_axi_rvalid_o && s_axi_rready_i)
            s_axi_rvalid_o <= 1'b0;
    end
endmodule

// ===== dv/fsrs_seq_asserts.sv
// fsrs_seq_asserts.sv: port-level checks of the self-rewrite sequencer
// assumes: bound into fsrs_sequencer, one clock, active-low async reset
`timescale 1ns/1ns
module fsrs_seq_chk
#(
    parameter [31:0] ERASE_CYCLES = 32'h0000_0014,
    parameter [31:0] WRITE_CYCLES = 32'h0000_0008
)
(
    input wire        sys_clk_i,
    input wire        arst_n_i,
    input wire        s_axi_awvalid_i,
    input wire        s_axi_awready_o,
    input wire        s_axi_wvalid_i,
    input wire        s_axi_wready_o,
    input wire        s_axi_bvalid_o,
    input wire        s_axi_arvalid_i,
    input wire        s_axi_arready_o,
    input wire        s_axi_rvalid_o,
    input wire        flash_erase_o,
    input wire        flash_block_o,
    input wire        flash_program_o,
    input wire [2:0]  flash_segment_o,
    input wire [15:0] flash_addr_o,
    input wire        rewrite_done_irq_o
);
    reg [31:0] run_len;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // one length counter: erase and word write never overlap
    always @(posedge sys_clk_i or negedge arst_n_i)
        if (!arst_n_i)
            run_len <= 32'h0000_0000;
        else if (flash_erase_o | flash_program_o)
            run_len <= run_len + 32'h0000_0001;
        else
            run_len <= 32'h0000_0000;
    a_erase_len: assert property ($fell(flash_erase_o) |-> run_len == ERASE_CYCLES)
        else $error("erase busy length wrong");
    a_write_len: assert property ($fell(flash_program_o) |-> run_len == WRITE_CYCLES)
        else $error("word write busy length wrong");
    a_done_follows: assert property (($fell(flash_erase_o) || $fell(flash_program_o))
        |-> ##[0:2] rewrite_done_irq_o) else $error("no done pulse after operation");
    a_done_pulse: assert property (rewrite_done_irq_o |=> !rewrite_done_irq_o)
        else $error("done pulse longer than one cycle");
    a_one_op: assert property (!(flash_erase_o && flash_program_o))
        else $error("erase and write at once");
    a_sector_align: assert property (flash_erase_o && !flash_block_o
        |-> flash_addr_o[8:0] == 9'h000) else $error("sector address not aligned");
    a_block_align: assert property (flash_erase_o && flash_block_o
        |-> flash_addr_o[10:0] == 11'h000) else $error("block address not aligned");
    a_word_align: assert property (flash_program_o |-> !flash_addr_o[0])
        else $error("word address odd");
    a_target_hold: assert property (flash_erase_o && $past(flash_erase_o)
        |-> $stable(flash_addr_o) && $stable(flash_block_o)) else $error("target moved");
    a_seg_four: assert property ($rose(flash_erase_o) || $rose(flash_program_o)
        |-> flash_segment_o == 3'h4) else $error("operation outside data segment");
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |=> s_axi_bvalid_o) else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read response late");
    cover property (flash_erase_o && !flash_block_o);
    cover property (flash_erase_o && flash_block_o);
    cover property (flash_program_o);
    cover property (rewrite_done_irq_o);
endmodule
bind fsrs_sequencer fsrs_seq_chk #(.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES))
    i_fsrs_seq_chk
(
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .flash_erase_o(flash_erase_o),
    .flash_block_o(flash_block_o), .flash_program_o(flash_program_o),
    .flash_segment_o(flash_segment_o), .flash_addr_o(flash_addr_o),
    .rewrite_done_irq_o(rewrite_done_irq_o)
);

// ===== dv/fsrs_cpu_model.sv
// fsrs_cpu_model.sv: cpu side bus master issuing register writes and reads
// assumes: tasks are entered just after a rising edge, bready/rready held high
`timescale 1ns/1ns
module fsrs_cpu_model
(
    input  wire        sys_clk_i,
    output reg  [7:0]  awaddr_o,
    output reg         awvalid_o,
    input  wire        awready_i,
    output reg  [31:0] wdata_o,
    output reg         wvalid_o,
    input  wire        wready_i,
    input  wire [1:0]  bresp_i,
    input  wire        bvalid_i,
    output reg  [7:0]  araddr_o,
    output reg         arvalid_o,
    input  wire        arready_i,
    input  wire [31:0] rdata_i,
    input  wire [1:0]  rresp_i,
    input  wire        rvalid_i
);
    initial
    begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, araddr_o, arvalid_o} = 0;
    end
    // released lines flip so stale values cannot pass for live ones
    task wr(input [7:0] a, input [31:0] d, output [1:0] r);
        begin
            awaddr_o <= a;
            wdata_o <= d;
            awvalid_o <= 1'b1;
            wvalid_o <= 1'b1;
            do
            begin
                @(posedge sys_clk_i);
                if (awvalid_o && awready_i)
                    {awvalid_o, awaddr_o} <= {1'b0, ~a};
                if (wvalid_o && wready_i)
                    {wvalid_o, wdata_o} <= {1'b0, ~d};
            end
            while (!bvalid_i);
            r = bresp_i;
        end
    endtask
    task rd(input [7:0] a, output [31:0] d, output [1:0] r);
        begin
            araddr_o <= a;
            arvalid_o <= 1'b1;
            do
            begin
                @(posedge sys_clk_i);
                if (arvalid_o && arready_i)
                    {arvalid_o, araddr_o} <= {1'b0, ~a};
            end
            while (!rvalid_i);
            d = rdata_i;
            r = rresp_i;
        end
    endtask
endmodule

// ===== dv/tb.sv
// tb.sv: self-checking bench of the self-rewrite sequencer
// assumes: short busy counts of 20 and 8 cycles, 250 MHz clock
`timescale 1ns/1ns
module tb;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [1:0] b; logic [7:0] q;} fsrs_row_t;
    typedef struct packed {logic [7:0] h; logic [7:0] a; logic [7:0] d; logic [1:0] k;} fsrs_prot_t;
    reg         sys_clk_i;
    reg         arst_n_i;
    wire        awv, awr, wv, wr_, bv, arv, arr, rv, f_er, f_bk, f_pg, irq;
    wire [7:0]  awa, ara;
    wire [31:0] wd, rdat;
    wire [1:0]  br, rr;
    wire [2:0]  f_seg;
    wire [15:0] f_addr, f_data;
    int         n_fail, num_checks, n_irq, cycles, i;
    reg [15:0]  cap_addr, cap_data;
    reg         cap_blk, cap_pg;
    reg [31:0]  q;
    reg [1:0]   r;
    fsrs_row_t rows [0:8] = '{'{8'h00, 8'h12, 2'b00, 8'h00}, '{8'h04, 8'hFC, 2'b00, 8'h04},
        '{8'h08, 8'hA5, 2'b00, 8'hA5}, '{8'h0C, 8'h3C, 2'b00, 8'h3C},
        '{8'h10, 8'h5A, 2'b00, 8'h5A}, '{8'h20, 8'hFF, 2'b00, 8'h01},
        '{8'h24, 8'h00, 2'b00, 8'h00}, '{8'h28, 8'h11, 2'b10, 8'h00},
        '{8'h02, 8'h11, 2'b10, 8'h00}};
    // protect bit 2 set: range 0400H-05FFH closed, block erase of 0000H-07FFH closed
    fsrs_prot_t prot [0:5] = '{'{8'h05, 8'h18, 8'h01, 2'd0}, '{8'h07, 8'h18, 8'h01, 2'd1},
        '{8'h04, 8'h14, 8'h99, 2'd0}, '{8'h06, 8'h14, 8'h99, 2'd2},
        '{8'h00, 8'h18, 8'h03, 2'd0}, '{8'h08, 8'h18, 8'h03, 2'd1}};
    fsrs_sequencer #(.ERASE_CYCLES(32'h0000_0014), .WRITE_CYCLES(32'h0000_0008)) i_fsrs_sequencer
    (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_), .s_axi_bresp_o(br),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1), .s_axi_araddr_i(ara),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat),
        .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1), .flash_erase_o(f_er),
        .flash_block_o(f_bk), .flash_program_o(f_pg), .flash_segment_o(f_seg),
        .flash_addr_o(f_addr), .flash_data_o(f_data), .rewrite_done_irq_o(irq)
    );
    fsrs_cpu_model i_fsrs_cpu_model
    (
        .sys_clk_i(sys_clk_i), .awaddr_o(awa), .awvalid_o(awv), .awready_i(awr),
        .wdata_o(wd), .wvalid_o(wv), .wready_i(wr_), .bresp_i(br), .bvalid_i(bv),
        .araddr_o(ara), .arvalid_o(arv), .arready_i(arr), .rdata_i(rdat), .rresp_i(rr),
        .rvalid_i(rv)
    );
    // only the fast system clock is ever modelled
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    task wrap_up;
        begin
            $display("checks %0d errors %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    always @(posedge sys_clk_i)
    begin
        if (irq === 1'b1)
            n_irq = n_irq + 1;
        if (f_er === 1'b1 || f_pg === 1'b1)
            {cap_addr, cap_data, cap_blk, cap_pg} = {f_addr, f_data, f_bk, f_pg};
        cycles = cycles + 1;
        if (cycles == 6000)
        begin
            n_fail = n_fail + 1;
            wrap_up;
        end
    end
    task chk_val(input [31:0] g, input [31:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e)
            begin
                n_fail = n_fail + 1;
                $display("unexpected value at %0t: got %h exp %h", $time, g, e);
            end
        end
    endtask
    task chk_resp(input [1:0] g, input [1:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e)
            begin
                n_fail = n_fail + 1;
                $display("unexpected response at %0t: got %h exp %h", $time, g, e);
            end
        end
    endtask
    task w(input [7:0] a, input [7:0] d);
        reg [1:0] rs;
        begin
            i_fsrs_cpu_model.wr(a, {24'h00_0000, d}, rs);
            chk_resp(rs, 2'b00);
        end
    endtask
    task unlock;
        begin
            w(8'h00, 8'hFA);
            w(8'h00, 8'hF5);
        end
    endtask
    // k: expected status after the start, 1 erase busy, 2 write busy, 0 refused
    task go(input [7:0] a, input [7:0] d, input [1:0] k);
        int n0;
        begin
            n0 = n_irq;
            w(a, d);
            repeat (2) @(posedge sys_clk_i);
            i_fsrs_cpu_model.rd(8'h1C, q, r);
            chk_val(q, {30'h0000_0000, k});
            repeat (40) @(posedge sys_clk_i);
            chk_val(n_irq - n0, (k != 2'd0));
            i_fsrs_cpu_model.rd(8'h1C, q, r);
            chk_val(q, 32'h0000_0000);
        end
    endtask
    initial
    begin
        {n_fail, num_checks, n_irq, cycles} = 0;
        arst_n_i = 1'b0;
        repeat (5) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        for (i = 0; i < 9; i++)
        begin
            i_fsrs_cpu_model.wr(rows[i].a, {24'h00_0000, rows[i].d}, r);
            chk_resp(r, rows[i].b);
            i_fsrs_cpu_model.rd(rows[i].a, q, r);
            chk_val(q, {24'h00_0000, rows[i].q});
            chk_resp(r, rows[i].b);
        end
        w(8'h20, 8'h01);
        w(8'h04, 8'h04);
        w(8'h0C, 8'h05);
        unlock;
        go(8'h18, 8'h01, 2'd1);
        chk_val({cap_blk, cap_addr}, 17'h0_0400);
        go(8'h18, 8'h01, 2'd0);
        w(8'h0C, 8'h0F);
        unlock;
        go(8'h18, 8'h03, 2'd1);
        chk_val({cap_blk, cap_addr}, 17'h1_0800);
        w(8'h0C, 8'h12);
        w(8'h08, 8'h35);
        w(8'h10, 8'hCD);
        unlock;
        go(8'h14, 8'hAB, 2'd2);
        chk_val({cap_addr, cap_data}, 32'h1234_ABCD);
        w(8'h20, 8'h00);
        unlock;
        go(8'h18, 8'h01, 2'd0);
        w(8'h20, 8'h01);
        w(8'h00, 8'hFA);
        w(8'h00, 8'h11);
        w(8'h00, 8'hF5);
        go(8'h18, 8'h01, 2'd0);
        unlock;
        w(8'h18, 8'h01);
        unlock;
        go(8'h14, 8'h77, 2'd1);
        chk_val(cap_pg, 1'b0);
        w(8'h04, 8'h03);
        unlock;
        go(8'h18, 8'h01, 2'd0);
        w(8'h04, 8'h04);
        go(8'h18, 8'h01, 2'd0);
        w(8'h24, 8'h04);
        w(8'h24, 8'h00);
        i_fsrs_cpu_model.rd(8'h24, q, r);
        chk_val(q, 32'h0000_0004);
        for (i = 0; i < 6; i++)
        begin
            w(8'h0C, prot[i].h);
            unlock;
            go(prot[i].a, prot[i].d, prot[i].k);
        end
        w(8'h24, 8'h08);
        w(8'h0C, 8'h06);
        unlock;
        go(8'h14, 8'h99, 2'd0);
        w(8'h20, 8'h00);
        // mid-run reset must clear the sticky protection
        arst_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        i_fsrs_cpu_model.rd(8'h24, q, r);
        chk_val(q, 32'h0000_0000);
        wrap_up;
    end
endmodule
